// *** logic/comparator_pkg.sv ***
// Register map, field layout and constants of the triple comparator control block
package comparator_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PINSEL_B = 8'hce;
  localparam logic [7:0] IDX_CTL2 = 8'hcf;
  localparam logic [7:0] IDX_PINSEL_A = 8'hf6;
  localparam logic [7:0] IDX_CTL0 = 8'hfe;
  localparam logic [7:0] IDX_CTL1 = 8'hff;
  localparam logic [7:0] IDX_INT_STATUS = 8'h10;
  localparam logic [7:0] IDX_INT_CLEAR = 8'h11;
  localparam logic [7:0] IDX_INT_ENABLE = 8'h12;
  localparam logic [7:0] IDX_OUT_ENABLE = 8'h13;

  // Control register fields
  localparam int HYS_BIT = 7;
  localparam int RESULT_BIT = 6;
  localparam int MODE_HI = 5;
  localparam int MODE_LO = 4;
  localparam int FLAG_BIT = 3;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // Pin-select fields: unit 0 and unit 2 in the upper nibble, unit 1 in the lower
  localparam int EN_HI = 6;
  localparam int REF_HI = 5;
  localparam int PAD_HI = 4;
  localparam int EN_LO = 2;
  localparam int REF_LO = 1;
  localparam int PAD_LO = 0;
  localparam logic [7:0] PINSEL_A_MASK = 8'h77;
  localparam logic [7:0] PINSEL_B_MASK = 8'h70;
  localparam logic [7:0] PINSEL_RESET = 8'h00;

  // Strap settle: two synchroniser stages before the pin-select load
  localparam logic [1:0] STRAP_SETTLE = 2'd2;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    EDGE_TOGGLE = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_RESERVED = 2'b11
  } edge_mode_type;

endpackage : comparator_pkg

// *** logic/triple_comparator_control.sv ***
// Control and status of three comparators behind an AXI4-Lite register slave
// How it works
// - Result is one when positive input exceeds negative input, else zero.
// - Amplifier mode on a unit overrides and disables its comparator function.
// - Enable one turns comparator on; reference source takes both pins, pad source only the negative pin unless output enabled.
// - Two bits pick positive source: internal reference or external pin.
// - With enable zero both pins stay ordinary I/O regardless of settings.
// - Control bit 7 enables input hysteresis when one.
// - Control bit 6 reads live comparator result, read only.
// - Two-bit mode picks toggle, rising or falling; code 11 reserved.
// - Hardware sets flag on chosen edge; only software zero clears it.
// - Control registers reset to zero; pin selects load from option bits.
// - Unit 2 reference bit picks bandgap, pad bit picks external pin.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
module triple_comparator_control #(
  parameter int ADDR_W = 10,
  parameter int UNITS = 3
) (
  input wire logic core_clk,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog side and straps
  input wire logic [UNITS-1:0] unitResult,
  input wire logic [UNITS-1:0] amplifierMode,
  input wire logic [7:0] optionBitsA,
  input wire logic [7:0] optionBitsB,
  output logic [UNITS-1:0] unitPower,
  output logic [UNITS-1:0] posRefConnect,
  output logic [UNITS-1:0] posPinConnect,
  output logic [UNITS-1:0] hysteresisOn,
  output logic [UNITS-1:0] posPinTakeover,
  output logic [UNITS-1:0] negPinTakeover,
  output logic irq
);

  logic [7:0] optFirstA;
  logic [7:0] optSyncA;
  logic [7:0] optFirstB;
  logic [7:0] optSyncB;
  logic [1:0] loadCount;
  logic loaded;
  logic [7:0] pinSelA;
  logic [7:0] pinSelB;
  logic [UNITS-1:0] outPinEnable;
  logic [UNITS-1:0] intStatus;
  logic [UNITS-1:0] intEnable;
  logic [7:0] writeIdx;
  logic [31:0] writeData;
  logic [3:0] writeStrb;
  logic awHeld;
  logic wHeld;
  logic doWrite;
  logic byteWrite;
  logic [7:0] readIdx;
  logic [31:0] readValue;
  logic readHit;
  logic writeHit;
  logic [UNITS-1:0] enBit;
  logic [UNITS-1:0] refBit;
  logic [UNITS-1:0] padBit;
  logic [UNITS-1:0] active;
  logic [UNITS-1:0] ctlWrite;
  logic [UNITS-1:0] events;
  logic [7:0] ctlValue [UNITS];
  logic [7:0] ctlIdx [UNITS];

  assign ctlIdx[0] = comparator_pkg::IDX_CTL0;
  assign ctlIdx[1] = comparator_pkg::IDX_CTL1;
  assign ctlIdx[2] = comparator_pkg::IDX_CTL2;

  // Strap synchroniser for the option bits
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      optFirstA <= comparator_pkg::PINSEL_RESET;
      optSyncA <= comparator_pkg::PINSEL_RESET;
      optFirstB <= comparator_pkg::PINSEL_RESET;
      optSyncB <= comparator_pkg::PINSEL_RESET;
    end else begin
      optFirstA <= optionBitsA;
      optSyncA <= optFirstA;
      optFirstB <= optionBitsB;
      optSyncB <= optFirstB;
    end
  end

  // Settle counter; bus stays closed until the straps are loaded
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      loadCount <= 2'd0;
      loaded <= 1'b0;
    end else if (!loaded) begin
      loadCount <= loadCount + 2'd1;
      loaded <= (loadCount == comparator_pkg::STRAP_SETTLE);
    end
  end

  // Field decode of the pin-select registers
  assign enBit = {pinSelB[comparator_pkg::EN_HI], pinSelA[comparator_pkg::EN_LO], pinSelA[comparator_pkg::EN_HI]};
  assign refBit = {pinSelB[comparator_pkg::REF_HI], pinSelA[comparator_pkg::REF_LO], pinSelA[comparator_pkg::REF_HI]};
  assign padBit = {pinSelB[comparator_pkg::PAD_HI], pinSelA[comparator_pkg::PAD_LO], pinSelA[comparator_pkg::PAD_HI]};
  assign active = enBit & ~amplifierMode;

  // Write address channel
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      awHeld <= 1'b0;
      writeIdx <= 8'h00;
    end else if (s_axi_awready && s_axi_awvalid) begin
      s_axi_awready <= 1'b0;
      awHeld <= 1'b1;
      writeIdx <= s_axi_awaddr[ADDR_W-1:2];
    end else begin
      if (doWrite) awHeld <= 1'b0;
      if ((s_axi_bvalid && s_axi_bready) || (!loaded && loadCount == comparator_pkg::STRAP_SETTLE)) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  // Write data channel
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_wready <= 1'b0;
      wHeld <= 1'b0;
      writeData <= comparator_pkg::READ_ZERO;
      writeStrb <= 4'h0;
    end else if (s_axi_wready && s_axi_wvalid) begin
      s_axi_wready <= 1'b0;
      wHeld <= 1'b1;
      writeData <= s_axi_wdata;
      writeStrb <= s_axi_wstrb;
    end else begin
      if (doWrite) wHeld <= 1'b0;
      if ((s_axi_bvalid && s_axi_bready) || (!loaded && loadCount == comparator_pkg::STRAP_SETTLE)) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  assign doWrite = awHeld & wHeld & ~s_axi_bvalid;
  assign byteWrite = doWrite & writeStrb[0];

  // Write decode
  always_comb begin
    writeHit = 1'b0;
    unique case (writeIdx)
      comparator_pkg::IDX_PINSEL_A, comparator_pkg::IDX_PINSEL_B, comparator_pkg::IDX_CTL0,
      comparator_pkg::IDX_CTL1, comparator_pkg::IDX_CTL2, comparator_pkg::IDX_INT_CLEAR,
      comparator_pkg::IDX_INT_ENABLE, comparator_pkg::IDX_OUT_ENABLE: writeHit = 1'b1;
      default: writeHit = 1'b0;
    endcase
  end

  // Write response; status register is read only and refuses writes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= comparator_pkg::RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= writeHit ? comparator_pkg::RESP_OKAY : comparator_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Pin-select registers: strap image at load, software afterwards
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pinSelA <= comparator_pkg::PINSEL_RESET;
      pinSelB <= comparator_pkg::PINSEL_RESET;
    end else if (!loaded) begin
      if (loadCount == comparator_pkg::STRAP_SETTLE) begin
        pinSelA <= ~optSyncA & comparator_pkg::PINSEL_A_MASK;
        pinSelB <= ~optSyncB & comparator_pkg::PINSEL_B_MASK;
      end
    end else if (byteWrite && writeIdx == comparator_pkg::IDX_PINSEL_A) begin
      pinSelA <= writeData[7:0] & comparator_pkg::PINSEL_A_MASK;
    end else if (byteWrite && writeIdx == comparator_pkg::IDX_PINSEL_B) begin
      pinSelB <= writeData[7:0] & comparator_pkg::PINSEL_B_MASK;
    end
  end

  // Output-pin enables and interrupt enables
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      outPinEnable <= '0;
      intEnable <= '0;
    end else if (byteWrite && writeIdx == comparator_pkg::IDX_OUT_ENABLE) begin
      outPinEnable <= writeData[UNITS-1:0];
    end else if (byteWrite && writeIdx == comparator_pkg::IDX_INT_ENABLE) begin
      intEnable <= writeData[UNITS-1:0];
    end
  end

  // Sticky interrupt status; a new event beats a clear in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      intStatus <= '0;
    end else if (byteWrite && writeIdx == comparator_pkg::IDX_INT_CLEAR) begin
      intStatus <= (intStatus & ~writeData[UNITS-1:0]) | events;
    end else begin
      intStatus <= intStatus | events;
    end
  end

  // Level interrupt
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) irq <= 1'b0;
    else irq <= |(intStatus & intEnable);
  end

  // One channel per comparator
  for (genvar u = 0; u < UNITS; u++) begin : g_unit
    assign ctlWrite[u] = byteWrite & (writeIdx == ctlIdx[u]);
    unit_channel channel (
      .core_clk(core_clk),
      .rst(rst),
      .rawResult(unitResult[u]),
      .active(active[u]),
      .ctlWrite(ctlWrite[u]),
      .writeData(writeData[7:0]),
      .ctlValue(ctlValue[u]),
      .eventPulse(events[u])
    );
  end

  // Analog steering and pin takeover
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      unitPower <= '0;
      posRefConnect <= '0;
      posPinConnect <= '0;
      hysteresisOn <= '0;
      posPinTakeover <= '0;
      negPinTakeover <= '0;
    end else begin
      for (int u = 0; u < UNITS; u++) begin
        unitPower[u] <= active[u];
        posRefConnect[u] <= active[u] & refBit[u];
        posPinConnect[u] <= active[u] & padBit[u];
        hysteresisOn[u] <= active[u] & ctlValue[u][comparator_pkg::HYS_BIT];
        // Reference source takes both pins; pad source takes only the negative pin unless output enabled
        posPinTakeover[u] <= active[u] & refBit[u] & ~padBit[u];
        negPinTakeover[u] <= active[u] & ((refBit[u] & ~padBit[u]) | (~refBit[u] & padBit[u] & ~outPinEnable[u]));
      end
    end
  end

  // Read decode
  always_comb begin
    readValue = comparator_pkg::READ_ZERO;
    readHit = 1'b1;
    unique case (readIdx)
      comparator_pkg::IDX_PINSEL_A: readValue[7:0] = pinSelA;
      comparator_pkg::IDX_PINSEL_B: readValue[7:0] = pinSelB;
      comparator_pkg::IDX_CTL0: readValue[7:0] = ctlValue[0];
      comparator_pkg::IDX_CTL1: readValue[7:0] = ctlValue[1];
      comparator_pkg::IDX_CTL2: readValue[7:0] = ctlValue[2];
      comparator_pkg::IDX_INT_STATUS: readValue[UNITS-1:0] = intStatus;
      comparator_pkg::IDX_INT_CLEAR: readValue = comparator_pkg::READ_ZERO;
      comparator_pkg::IDX_INT_ENABLE: readValue[UNITS-1:0] = intEnable;
      comparator_pkg::IDX_OUT_ENABLE: readValue[UNITS-1:0] = outPinEnable;
      default: readHit = 1'b0;
    endcase
  end

  assign readIdx = s_axi_araddr[ADDR_W-1:2];

  // Read channel: address taken, data one cycle later
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= comparator_pkg::READ_ZERO;
      s_axi_rresp <= comparator_pkg::RESP_OKAY;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readValue;
      s_axi_rresp <= readHit ? comparator_pkg::RESP_OKAY : comparator_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!loaded && loadCount == comparator_pkg::STRAP_SETTLE) begin
      s_axi_arready <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_amp_priority;
    amplifierMode[0] |=> !unitPower[0] && !posPinTakeover[0] && !negPinTakeover[0];
  endproperty
  a_amp_priority: assert property (p_amp_priority) else $error("comparator active in amplifier mode");

  property p_takeover;
    enBit[2] && !amplifierMode[2] && refBit[2] && !padBit[2] |=> unitPower[2] && posPinTakeover[2] && negPinTakeover[2];
  endproperty
  a_takeover: assert property (p_takeover) else $error("enabled unit did not take its pins");

  property p_disabled_io;
    !enBit[1] |=> !posPinTakeover[1] && !negPinTakeover[1] && !posRefConnect[1] && !posPinConnect[1];
  endproperty
  a_disabled_io: assert property (p_disabled_io) else $error("disabled unit holds a pin");

  property p_source_select;
    active[2] ##1 active[2] |-> posRefConnect[2] == $past(refBit[2]) && posPinConnect[2] == $past(padBit[2]);
  endproperty
  a_source_select: assert property (p_source_select) else $error("positive source not as selected");

  property p_hysteresis;
    active[0] |=> hysteresisOn[0] == $past(ctlValue[0][comparator_pkg::HYS_BIT]);
  endproperty
  a_hysteresis: assert property (p_hysteresis) else $error("hysteresis output mismatch");

  property p_strap_load;
    !loaded && loadCount == comparator_pkg::STRAP_SETTLE |=> pinSelA == (~$past(optSyncA) & comparator_pkg::PINSEL_A_MASK);
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("pin select not loaded from option bits");

  property p_int_sticky;
    events[1] |=> intStatus[1] ##1 (irq || !intEnable[1] || !$past(intEnable[1]));
  endproperty
  a_int_sticky: assert property (p_int_sticky) else $error("event lost from interrupt status");

endmodule : triple_comparator_control

// *** logic/unit_channel.sv ***
// One comparator channel: result synchroniser, edge-selected sticky flag, control register
`timescale 1ns/100ps
module unit_channel (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rawResult,
  input wire logic active,
  input wire logic ctlWrite,
  input wire logic [7:0] writeData,
  output logic [7:0] ctlValue,
  output logic eventPulse
);

  logic syncFirst;
  logic syncResult;
  logic prevResult;
  logic hysteresis;
  comparator_pkg::edge_mode_type edgeMode;
  logic flag;
  logic hit;

  // Two-stage synchroniser, then a history stage for edges
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      syncFirst <= 1'b0;
      syncResult <= 1'b0;
      prevResult <= 1'b0;
    end else begin
      syncFirst <= rawResult;
      syncResult <= syncFirst;
      prevResult <= syncResult;
    end
  end

  // Edge selection; reserved code never fires
  always_comb begin
    hit = 1'b0;
    unique case (edgeMode)
      comparator_pkg::EDGE_TOGGLE: hit = syncResult ^ prevResult;
      comparator_pkg::EDGE_RISE: hit = syncResult & ~prevResult;
      comparator_pkg::EDGE_FALL: hit = ~syncResult & prevResult;
      comparator_pkg::EDGE_RESERVED: hit = 1'b0;
    endcase
  end

  assign eventPulse = active & hit;

  // Writable configuration bits
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hysteresis <= comparator_pkg::CTL_RESET[comparator_pkg::HYS_BIT];
      edgeMode <= comparator_pkg::EDGE_TOGGLE;
    end else if (ctlWrite) begin
      hysteresis <= writeData[comparator_pkg::HYS_BIT];
      edgeMode <= comparator_pkg::edge_mode_type'(writeData[comparator_pkg::MODE_HI:comparator_pkg::MODE_LO]);
    end
  end

  // Sticky flag: hardware sets, only a software zero clears, set wins
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag <= comparator_pkg::CTL_RESET[comparator_pkg::FLAG_BIT];
    end else if (eventPulse) begin
      flag <= 1'b1;
    end else if (ctlWrite && !writeData[comparator_pkg::FLAG_BIT]) begin
      flag <= 1'b0;
    end
  end

  // Live result in bit 6, read only
  assign ctlValue = {hysteresis, syncResult, edgeMode, flag, 3'b000};

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_flag_set;
    eventPulse |=> flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set after event");

  property p_flag_hold;
    flag && !(ctlWrite && !writeData[comparator_pkg::FLAG_BIT]) |=> flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without software clear");

  property p_rise_only;
    active && edgeMode == comparator_pkg::EDGE_RISE && !flag && !ctlWrite && !(syncResult && !prevResult)
      |=> !flag;
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("flag set without rising edge");

  property p_status_delay;
    ctlValue[comparator_pkg::RESULT_BIT] == $past(rawResult, 2);
  endproperty
  a_status_delay: assert property (p_status_delay) else $error("status not two stages behind input");

endmodule : unit_channel

// *** tb/comparator_model.sv ***
// Behavioural model of the three analog comparators and their input pins
`timescale 1ns/100ps
module comparator_model #(
  parameter logic [7:0] REF_LEVEL = 8'h60
) (
  input wire logic [23:0] pinLevelPos,
  input wire logic [23:0] pinLevelNeg,
  input wire logic [2:0] unitPower,
  input wire logic [2:0] posRefConnect,
  output logic [2:0] unitResult
);
  // One unit: pick the positive source, then compare; unpowered reads zero
  function automatic logic cmpOne(input logic on, input logic useRef, input logic [7:0] p, input logic [7:0] n);
    logic [7:0] src;
    src = useRef ? REF_LEVEL : p;
    return on && (src > n);
  endfunction : cmpOne

  // Three units side by side
  assign unitResult[0] = cmpOne(unitPower[0], posRefConnect[0], pinLevelPos[7:0], pinLevelNeg[7:0]);
  assign unitResult[1] = cmpOne(unitPower[1], posRefConnect[1], pinLevelPos[15:8], pinLevelNeg[15:8]);
  assign unitResult[2] = cmpOne(unitPower[2], posRefConnect[2], pinLevelPos[23:16], pinLevelNeg[23:16]);
endmodule : comparator_model

// *** tb/triple_comparator_control_test.sv ***
// Self-checking bench for the triple comparator control block
`timescale 1ns/100ps
module triple_comparator_control_test;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] awaddr = 10'h000;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [9:0] araddr = 10'h000;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [2:0] amplifierMode = 3'h0;
  logic [23:0] pinLevelPos = 24'h101010;
  logic [23:0] pinLevelNeg = 24'h808080; // Mid level: 8'h10 reads low, 8'hf0 high, reference low
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] unitResult, unitPower, posRefConnect, posPinConnect, hysteresisOn, posPinTakeover, negPinTakeover;
  int fails = 0;
  int totalChecks = 0;
  int cycles = 0;

  // 10 MHz clock
  always #50 core_clk = ~core_clk;

  triple_comparator_control uut (
    .core_clk(core_clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .unitResult(unitResult), .amplifierMode(amplifierMode),
    .optionBitsA(8'hf9), .optionBitsB(8'h8f),
    .unitPower(unitPower), .posRefConnect(posRefConnect), .posPinConnect(posPinConnect),
    .hysteresisOn(hysteresisOn), .posPinTakeover(posPinTakeover), .negPinTakeover(negPinTakeover),
    .irq(irq)
  );

  comparator_model model (
    .pinLevelPos(pinLevelPos), .pinLevelNeg(pinLevelNeg), .unitPower(unitPower),
    .posRefConnect(posRefConnect), .unitResult(unitResult)
  );

  // Hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks=%0d fails=%0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(negedge core_clk);
  endtask : settle

  // Bus write, each channel released when taken; response compared
  task automatic wr(input logic [7:0] idx, input logic [7:0] data, input logic [1:0] expResp);
    @(posedge core_clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, data};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, expResp});
  endtask : wr

  // Bus read; data and response compared
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] expResp);
    @(posedge core_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, {24'h000000, exp});
    chk({30'h0, rresp}, {30'h0, expResp});
  endtask : rd

  function automatic logic [31:0] pins(input int u);
    return {27'h0, unitPower[u], posRefConnect[u], posPinConnect[u], posPinTakeover[u], negPinTakeover[u]};
  endfunction : pins

  task automatic testReset();
    rd(comparator_pkg::IDX_PINSEL_A, 8'h06, comparator_pkg::RESP_OKAY);
    rd(comparator_pkg::IDX_PINSEL_B, 8'h70, comparator_pkg::RESP_OKAY);
    rd(comparator_pkg::IDX_CTL0, 8'h00, comparator_pkg::RESP_OKAY);
    rd(comparator_pkg::IDX_CTL1, 8'h00, comparator_pkg::RESP_OKAY);
    rd(comparator_pkg::IDX_CTL2, 8'h00, comparator_pkg::RESP_OKAY);
    chk(pins(1), 32'h0000_001b);
    rd(8'h20, 8'h00, comparator_pkg::RESP_SLVERR);
    wr(comparator_pkg::IDX_INT_STATUS, 8'h01, comparator_pkg::RESP_SLVERR);
  endtask : testReset

  // Pin routing table, then amplifier override
  task automatic testPins();
    logic [7:0] idx [6];
    logic [7:0] val [6] = '{8'h60, 8'h50, 8'h50, 8'h30, 8'h70, 8'h60};
    logic [7:0] oe [6] = '{8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00};
    int unit [6] = '{0, 0, 0, 0, 0, 2};
    logic [31:0] exp [6] = '{32'h1b, 32'h15, 32'h14, 32'h00, 32'h1c, 32'h1b};
    idx = '{comparator_pkg::IDX_PINSEL_A, comparator_pkg::IDX_PINSEL_A, comparator_pkg::IDX_PINSEL_A,
      comparator_pkg::IDX_PINSEL_A, comparator_pkg::IDX_PINSEL_A, comparator_pkg::IDX_PINSEL_B};
    for (int i = 0; i < 6; i++) begin
      wr(comparator_pkg::IDX_OUT_ENABLE, oe[i], comparator_pkg::RESP_OKAY);
      wr(idx[i], val[i], comparator_pkg::RESP_OKAY);
      settle(3);
      chk(pins(unit[i]), exp[i]);
    end
    wr(comparator_pkg::IDX_PINSEL_A, 8'h60, comparator_pkg::RESP_OKAY);
    @(posedge core_clk) amplifierMode <= 3'h1;
    settle(3);
    chk({31'h0, unitPower[0]}, 32'h0);
    @(posedge core_clk) amplifierMode <= 3'h0;
  endtask : testPins

  // Every edge mode: rise then fall on unit 0
  task automatic testModes();
    int order [4] = '{3, 0, 1, 2};
    logic [1:0] md;
    logic expR, expF;
    wr(comparator_pkg::IDX_PINSEL_A, 8'h50, comparator_pkg::RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      md = order[i][1:0];
      expR = (md == 2'b00) || (md == 2'b01);
      expF = (md == 2'b00) || (md == 2'b10);
      wr(comparator_pkg::IDX_CTL0, {2'b10, md, 4'h0}, comparator_pkg::RESP_OKAY);
      @(posedge core_clk) pinLevelPos[7:0] <= 8'hf0;
      settle(6);
      chk({31'h0, hysteresisOn[0]}, 32'h1);
      rd(comparator_pkg::IDX_CTL0, {2'b11, md, expR, 3'h0}, comparator_pkg::RESP_OKAY);
      @(posedge core_clk) pinLevelPos[7:0] <= 8'h10;
      settle(6);
      rd(comparator_pkg::IDX_CTL0, {2'b10, md, expR | expF, 3'h0}, comparator_pkg::RESP_OKAY);
    end
    wr(comparator_pkg::IDX_CTL0, 8'ha0, comparator_pkg::RESP_OKAY);
    rd(comparator_pkg::IDX_CTL0, 8'ha0, comparator_pkg::RESP_OKAY);
  endtask : testModes

  // Interrupt raised, masked and cleared
  task automatic testIrq();
    rd(comparator_pkg::IDX_INT_STATUS, 8'h01, comparator_pkg::RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    wr(comparator_pkg::IDX_INT_ENABLE, 8'h01, comparator_pkg::RESP_OKAY);
    settle(2);
    chk({31'h0, irq}, 32'h1);
    wr(comparator_pkg::IDX_INT_ENABLE, 8'h00, comparator_pkg::RESP_OKAY);
    settle(2);
    chk({31'h0, irq}, 32'h0);
    wr(comparator_pkg::IDX_INT_ENABLE, 8'h01, comparator_pkg::RESP_OKAY);
    wr(comparator_pkg::IDX_INT_CLEAR, 8'h01, comparator_pkg::RESP_OKAY);
    settle(2);
    chk({31'h0, irq}, 32'h0);
    rd(comparator_pkg::IDX_INT_STATUS, 8'h00, comparator_pkg::RESP_OKAY);
  endtask : testIrq

  // Unit 1 on its own pin: rising edge sets its flag and status bit 1
  task automatic testUnit1();
    wr(comparator_pkg::IDX_PINSEL_A, 8'h05, comparator_pkg::RESP_OKAY);
    wr(comparator_pkg::IDX_CTL1, 8'h10, comparator_pkg::RESP_OKAY);
    @(posedge core_clk) pinLevelPos[15:8] <= 8'hf0;
    settle(6);
    rd(comparator_pkg::IDX_CTL1, 8'h58, comparator_pkg::RESP_OKAY);
    rd(comparator_pkg::IDX_INT_STATUS, 8'h02, comparator_pkg::RESP_OKAY);
  endtask : testUnit1

  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    repeat (5) @(posedge core_clk);
    testReset();
    testPins();
    testModes();
    testIrq();
    testUnit1();
    wrap_up();
  end
endmodule : triple_comparator_control_test
